// >>> rtl/conv_ctrl.sv
// Conversion start, busy and power-down control of the eight-channel converter.
// Summary of operation
// - Power-down high ignores conversion requests.
// - Power-down during conversion waits for completion.
// - Two power-down rises without conversion reset.
// - Strap pin selects LVDS or CMOS I/O.
// - Convert-start rise holds all channels, converts.
// - Chip-select never gates convert-start.
// - Busy rises at every conversion start.
// - Busy stays high until conversion ends.
module conv_ctrl (
   input wire clk,
   input wire arst_n,
   input wire convert_start,
   input wire power_down_request,
   input wire chip_select_n,
   input wire io_mode_strap,
   output logic busy,
   output logic hold,
   output logic powered_down,
   output logic global_reset,
   output conv_ctrl_pkg::io_mode_t io_mode,
   output logic conv_done
);
   import conv_ctrl_pkg::*;

   // Advances a cycle counter by one; shared by the conversion and reset counts
   // so that both wrap the same way at counter width.
   function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] cnt);
      return cnt + 8'h01;
   endfunction

   // Edge pulses from the input detector.
   edge_if edges ();

   // Whole controller state in one struct.
   typedef struct packed {
      state_t state;
      logic [CNT_W-1:0] cnt;
      logic pd_armed; // A power-down rise seen since the last conversion.
      logic pd_pending; // Power-down requested during the running conversion.
      logic busy;
      logic hold;
      logic powered_down;
      logic global_reset;
      io_mode_t io_mode;
      logic strap_taken; // Strap sampled once after reset release.
      logic conv_done;
   } ctrl_state_t;
   ctrl_state_t st;
   ctrl_state_t next_st;

   // Edge detector instance; chip select is deliberately not connected to it.
   edge_detect u_edge (
      .clk(clk),
      .arst_n(arst_n),
      .convert_start(convert_start),
      .power_down_request(power_down_request),
      .edges(edges)
   );

   // Next-state logic for conversion, power-down and global reset.
   always_comb begin
      next_st = st;
      next_st.conv_done = 1'b0;
      // Strap is caught on the first clock after reset release.
      if (!st.strap_taken) begin
         next_st.io_mode = io_mode_strap ? IO_LVDS : IO_CMOS;
         next_st.strap_taken = 1'b1;
      end
      case (st.state)
         ST_IDLE: begin
            if (edges.pd_rise) begin
               // A second rise with no conversion between triggers reset.
               if (st.pd_armed) begin
                  next_st.state = ST_GRST;
                  next_st.cnt = CNT_RESET;
                  next_st.global_reset = 1'b1;
                  // Power stays down from the very first reset cycle.
                  next_st.powered_down = 1'b1;
               end else begin
                  next_st.state = ST_DOWN;
                  next_st.pd_armed = 1'b1;
                  next_st.powered_down = 1'b1;
               end
            end else if (edges.conv_rise && !edges.pd_level) begin
               // Start regardless of chip select.
               next_st.state = ST_CONV;
               next_st.cnt = CNT_RESET;
               next_st.busy = 1'b1;
               next_st.hold = 1'b1;
               next_st.pd_armed = 1'b0;
            end
         end
         ST_CONV: begin
            // Note a power-down request but finish the conversion first.
            if (edges.pd_rise) begin
               next_st.pd_pending = 1'b1;
            end
            if (st.cnt == CONV_LAST) begin
               next_st.busy = 1'b0;
               next_st.hold = 1'b0;
               next_st.conv_done = 1'b1;
               if (st.pd_pending || edges.pd_rise) begin
                  next_st.state = ST_DOWN;
                  next_st.powered_down = 1'b1;
                  next_st.pd_armed = 1'b1;
                  next_st.pd_pending = 1'b0;
               end else begin
                  next_st.state = ST_IDLE;
               end
            end else begin
               // Count on toward the terminal count.
               next_st.cnt = cnt_step(st.cnt);
            end
         end
         ST_DOWN: begin
            // Requests are ignored while power-down is high.
            // Convert-start edges are simply dropped in this state.
            if (!edges.pd_level) begin
               next_st.state = ST_IDLE;
               next_st.powered_down = 1'b0;
            end
         end
         default: begin
            // Global reset: clear conversion state, then go to the down state.
            next_st.busy = 1'b0;
            next_st.hold = 1'b0;
            next_st.powered_down = 1'b1;
            next_st.pd_armed = 1'b0;
            next_st.pd_pending = 1'b0;
            if (st.cnt == GRST_LAST) begin
               next_st.global_reset = 1'b0;
               next_st.state = ST_DOWN;
            end else begin
               // Keep the reset pulse up for its fixed length.
               next_st.cnt = cnt_step(st.cnt);
            end
         end
      endcase
   end

   // Register the controller state.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs come straight from the state flip-flops.
   assign busy = st.busy;
   assign hold = st.hold;
   assign powered_down = st.powered_down;
   assign global_reset = st.global_reset;
   assign io_mode = st.io_mode;
   assign conv_done = st.conv_done;

   // Checks next to the logic they guard.
   // Power-down high blocks any new conversion, whatever the state.
   AST_PD_IGNORES: assert property (@(posedge clk) disable iff (!arst_n)
      (edges.conv_rise && edges.pd_level && !busy) |=> !busy)
      else $error("Conversion started while power-down high.");
   // The down state always shows on its output, never together with busy.
   AST_PD_LEVEL: assert property (@(posedge clk) disable iff (!arst_n)
      (st.state == ST_DOWN) |-> (powered_down && !busy))
      else $error("Down state without power-down output.");
   // A power-down rise during a conversion lets it run to its end.
   AST_PD_WAITS: assert property (@(posedge clk) disable iff (!arst_n)
      (busy && edges.pd_rise) |=> busy || (powered_down && conv_done))
      else $error("Power-down cut a conversion short.");
   // A second rise with no conversion between gives the reset pulse.
   AST_DOUBLE_PD: assert property (@(posedge clk) disable iff (!arst_n)
      (st.state == ST_IDLE && st.pd_armed && edges.pd_rise) |=> global_reset [*4])
      else $error("Double power-down gave no global reset.");
   // The device stays powered down and idle during the reset pulse.
   AST_GRST_DOWN: assert property (@(posedge clk) disable iff (!arst_n)
      global_reset |-> (powered_down && !busy && !hold))
      else $error("Global reset while awake or converting.");
   // After the pulse the pair detector starts afresh in the down state.
   AST_GRST_END: assert property (@(posedge clk) disable iff (!arst_n)
      $fell(global_reset) |-> (st.state == ST_DOWN && !st.pd_armed))
      else $error("Global reset did not end in a clean down state.");
   // The mode follows the strap level caught after reset release.
   AST_STRAP: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(st.strap_taken) |-> ((io_mode == IO_LVDS) == $past(io_mode_strap)))
      else $error("I/O mode does not follow the strap.");
   // Once caught, the mode no longer moves until the next reset.
   AST_STRAP_KEEP: assert property (@(posedge clk) disable iff (!arst_n)
      (st.strap_taken && $past(st.strap_taken)) |-> $stable(io_mode))
      else $error("I/O mode changed after it was caught.");
   // A start edge puts all channels in hold and raises busy.
   AST_START: assert property (@(posedge clk) disable iff (!arst_n)
      (st.state == ST_IDLE && edges.conv_rise && !edges.pd_level && !edges.pd_rise)
      |=> busy && hold)
      else $error("Convert-start edge did not start a conversion.");
   // Hold and busy move together for every conversion.
   AST_HOLD_BUSY: assert property (@(posedge clk) disable iff (!arst_n)
      hold == busy)
      else $error("Hold and busy disagree.");
   // A start is taken with the serial bus deselected as well.
   AST_CS_FREE: assert property (@(posedge clk) disable iff (!arst_n)
      (st.state == ST_IDLE && edges.conv_rise && !edges.pd_level && !edges.pd_rise
       && chip_select_n) |=> busy)
      else $error("Chip select blocked a conversion.");
   // Busy rises only as a conversion starts.
   AST_BUSY_RISE: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(busy) |-> st.state == ST_CONV && st.cnt == CNT_RESET)
      else $error("Busy rose outside a conversion start.");
   // Busy stays high over the first cycles of every conversion.
   AST_BUSY_LEN: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(busy) |-> busy [*8])
      else $error("Busy fell before the conversion ended.");
   // Busy cannot fall before the counter reaches its terminal count.
   AST_BUSY_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
      (busy && st.cnt != CONV_LAST) |=> busy)
      else $error("Busy fell before the terminal count.");
   // Busy falls only together with the finished pulse.
   AST_BUSY_END: assert property (@(posedge clk) disable iff (!arst_n)
      $fell(busy) && st.state != ST_GRST |-> conv_done)
      else $error("Busy fell without a finished conversion.");
   // The finished indication lasts a single cycle.
   AST_DONE_PULSE: assert property (@(posedge clk) disable iff (!arst_n)
      conv_done |=> !conv_done)
      else $error("Finished pulse lasted more than one cycle.");
endmodule

// >>> rtl/conv_ctrl_pkg.sv
// Package of constants, types and timing counts for the conversion control block.
package conv_ctrl_pkg;
   // Clock period in picoseconds.
   localparam int unsigned CLK_PERIOD_PS = 40000;
   // Typical conversion time per enabled channel, in nanoseconds.
   localparam int unsigned CONV_NS_PER_CH = 500;
   // Number of channels converted each time.
   localparam int unsigned NUM_CH = 8;
   // Conversion length in nanoseconds.
   localparam int unsigned CONV_NS = CONV_NS_PER_CH * NUM_CH;
   // Conversion length in clock cycles, rounded down, at least one.
   localparam int unsigned CONV_CYC_RAW = (CONV_NS * 1000) / CLK_PERIOD_PS;
   localparam int unsigned CONV_CYC = (CONV_CYC_RAW < 1) ? 1 : CONV_CYC_RAW;
   // Width of the conversion cycle counter.
   localparam int unsigned CNT_W = 8;
   // Terminal count of a conversion, at counter width.
   localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);
   // Terminal count of the internal global reset pulse; the pulse lasts four cycles.
   localparam logic [CNT_W-1:0] GRST_LAST = 8'h03;
   // Reset value of the counter.
   localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
   // Serial I/O standards selected by the strap.
   typedef enum logic {IO_CMOS, IO_LVDS} io_mode_t;
   // Main controller states.
   typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_DOWN, ST_GRST} state_t;
endpackage

// >>> rtl/edge_if.sv
// Interface carrying the unregistered power-down input level and the detected input edges.
interface edge_if;
   logic conv_rise; // One-cycle pulse on a convert-start rising edge.
   logic pd_rise; // One-cycle pulse on a power-down rising edge.
   logic pd_level; // Unregistered power-down input level.
   modport src (output conv_rise, pd_rise, pd_level);
   modport dst (input conv_rise, pd_rise, pd_level);
endinterface

// >>> rtl/edge_detect.sv
// Rising edge detector for the convert-start and power-down inputs.
module edge_detect (
   input wire clk,
   input wire arst_n,
   input wire convert_start,
   input wire power_down_request,
   edge_if.src edges
);
   // State is the previous level of each input.
   typedef struct packed {
      logic conv_q;
      logic pd_q;
   } edge_state_t;
   edge_state_t st;
   edge_state_t next_st;

   // Remember the present levels for next cycle.
   always_comb begin
      next_st.conv_q = convert_start;
      next_st.pd_q = power_down_request;
   end

   // Register the levels.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // A rise is now high while the last cycle was low.
   assign edges.conv_rise = convert_start & ~st.conv_q;
   assign edges.pd_rise = power_down_request & ~st.pd_q;
   assign edges.pd_level = power_down_request;
endmodule

// >>> testbench/ctrl_model.sv
// Controller model that sequences conversion and power-down requests.
module ctrl_model (
   input wire clk,
   input wire busy,
   output logic convert_start,
   output logic power_down_request
);
   timeunit 1ns;
   timeprecision 1ps;
   // Both requests start low, so nothing is asked before reset ends.
   initial begin
      convert_start = 1'b0;
      power_down_request = 1'b0;
   end
   // Gives one convert-start rising edge, held high for two cycles.
   task automatic pulse_cnv();
      @(posedge clk) #1 convert_start = 1'b1;
      repeat (2) @(posedge clk);
      #1 convert_start = 1'b0;
   endtask
   // Waits, with a bound, for busy to fall before results are used.
   task automatic wait_idle();
      int n;
      n = 0;
      @(negedge clk);
      while (busy === 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
   endtask
   // Sets the power-down level just after a clock edge.
   task automatic set_pd(input logic lvl);
      @(posedge clk) #1 power_down_request = lvl;
   endtask
endmodule

// >>> testbench/adc_conversion_power_control_tb.sv
// Self-checking bench for the conversion and power-down control block.
module adc_conversion_power_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import conv_ctrl_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic chip_select_n;
   logic io_mode_strap;
   logic busy, hold, powered_down, global_reset, conv_done;
   logic convert_start, power_down_request;
   io_mode_t io_mode;
   logic [7:0] exp_q[$]; // Expected high-time of each busy or global reset run.
   int miscompares = 0;
   int checks = 0;
   int cycles = 0;
   logic [7:0] blen = 8'h00;
   logic [7:0] glen = 8'h00;
   always #20 clk = ~clk;
   conv_ctrl conv_ctrl_inst (.clk(clk), .arst_n(arst_n), .convert_start(convert_start),
      .power_down_request(power_down_request), .chip_select_n(chip_select_n),
      .io_mode_strap(io_mode_strap), .busy(busy), .hold(hold), .powered_down(powered_down),
      .global_reset(global_reset), .io_mode(io_mode), .conv_done(conv_done));
   ctrl_model ctrl_model_inst (.clk(clk), .busy(busy), .convert_start(convert_start),
      .power_down_request(power_down_request));
   // Compares one value and reports a mismatch at once.
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (exp !== got) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic final_report();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Watches the outputs and takes the oldest note when a run ends.
   always @(negedge clk) begin
      if (!arst_n) begin
         blen = 8'h00;
         glen = 8'h00;
      end else begin
         if (hold !== busy) chk("hold", {7'h00, busy}, {7'h00, hold});
         if (busy === 1'b1) blen++;
         else if (blen != 8'h00) begin
            chk("conv_done", 8'h01, {7'h00, conv_done});
            chk("busy_len", (exp_q.size() > 0) ? exp_q.pop_front() : 8'h00, blen);
            blen = 8'h00;
         end
         if (global_reset === 1'b1) glen++;
         else if (glen != 8'h00) begin
            chk("grst_len", (exp_q.size() > 0) ? exp_q.pop_front() : 8'h00, glen);
            glen = 8'h00;
         end
      end
   end
   // Cuts a hang short.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         miscompares++;
         final_report();
      end
   end
   // Applies reset for six cycles with the given strap level.
   task automatic do_reset(input logic strap);
      #1 arst_n = 1'b0;
      io_mode_strap = strap;
      repeat (6) @(posedge clk);
      #1 arst_n = 1'b1;
      repeat (3) @(posedge clk);
   endtask
   // Notes one conversion and runs it, flipping the random chip-select level each time.
   task automatic conv_run();
      exp_q.push_back(8'(CONV_CYC));
      #1 chip_select_n = ~chip_select_n;
      ctrl_model_inst.pulse_cnv();
      ctrl_model_inst.wait_idle();
   endtask
   // Main sequence.
   initial begin
      void'($urandom(53609));
      chip_select_n = 1'($urandom);
      do_reset(1'b1);
      chk("io_mode", 8'h01, {7'h00, io_mode});
      do_reset(1'b0);
      chk("io_mode", 8'h00, {7'h00, io_mode});
      conv_run();
      conv_run();
      // A start while powered down is ignored, so nothing is noted.
      ctrl_model_inst.set_pd(1'b1);
      repeat (2) @(negedge clk);
      chk("powered_down", 8'h01, {7'h00, powered_down});
      ctrl_model_inst.pulse_cnv();
      repeat (5) @(negedge clk);
      chk("busy_in_pd", 8'h00, {7'h00, busy});
      ctrl_model_inst.set_pd(1'b0);
      repeat (3) @(posedge clk);
      conv_run();
      // Power-down rising mid-conversion waits for the conversion to end.
      exp_q.push_back(8'(CONV_CYC));
      ctrl_model_inst.pulse_cnv();
      ctrl_model_inst.set_pd(1'b1);
      repeat (5) @(negedge clk);
      chk("busy_kept", 8'h01, {7'h00, busy});
      ctrl_model_inst.wait_idle();
      repeat (2) @(negedge clk);
      chk("pd_after", 8'h01, {7'h00, powered_down});
      ctrl_model_inst.set_pd(1'b0);
      repeat (3) @(posedge clk);
      conv_run();
      // Two power-down pulses with no conversion between give a reset.
      exp_q.push_back(8'h04);
      ctrl_model_inst.set_pd(1'b1);
      repeat (3) @(posedge clk);
      ctrl_model_inst.set_pd(1'b0);
      repeat (3) @(posedge clk);
      ctrl_model_inst.set_pd(1'b1);
      repeat (10) @(negedge clk);
      chk("pd_grst", 8'h01, {7'h00, powered_down});
      ctrl_model_inst.set_pd(1'b0);
      repeat (3) @(posedge clk);
      conv_run();
      repeat (5) @(posedge clk);
      chk("notes_left", 8'h00, 8'(exp_q.size()));
      final_report();
   end
endmodule
